// ---- fepc_regs.svh ----
`ifndef FEPC_REGS_SVH
`define FEPC_REGS_SVH
// Register byte offsets.
`define FEPC_OFF_READY 12'h400
`define FEPC_OFF_CONFIG 12'h504
`define FEPC_OFF_ERASEPG 12'h508
`define FEPC_OFF_FULLERASE 12'h50c
`define FEPC_OFF_ALIASB 12'h510
`define FEPC_OFF_USERERASE 12'h514
`define FEPC_OFF_PARTADDR 12'h518
`define FEPC_OFF_PARTDUR 12'h51c
// Reset values.
`define FEPC_RST_READY 32'h00000001
`define FEPC_RST_MODE 2'h0
`define FEPC_RST_DUR 32'h0000000a
// Access mode encodings.
`define FEPC_MODE_READ 2'h0
`define FEPC_MODE_WRITE 2'h1
`define FEPC_MODE_ERASE 2'h2
// Times in their own units and clock rate in kHz.
`define FEPC_CLK_KHZ 50000
`define FEPC_WRITE_US 41
`define FEPC_PAGE_MS 85
`define FEPC_ALL_MS 169
// Cycle counts derived from the times; only the write count divides, and it comes out exact.
`define FEPC_WRITE_CYC ((`FEPC_WRITE_US * `FEPC_CLK_KHZ) / 1000)
`define FEPC_PAGE_CYC (`FEPC_PAGE_MS * `FEPC_CLK_KHZ)
`define FEPC_ALL_CYC (`FEPC_ALL_MS * `FEPC_CLK_KHZ)
`define FEPC_MS_CYC (`FEPC_CLK_KHZ)
// Page is 4 kB: address bits above this select the page.
`define FEPC_PAGE_LSB 12
`define FEPC_PAGE_BITS 20
`endif

// ---- fepc_pkg.sv ----
package fepc_pkg;
	// Operation sequencer states.
	typedef enum logic [2:0] {
		FEPC_IDLE,
		FEPC_WRITE,
		FEPC_PAGE,
		FEPC_PARTIAL,
		FEPC_USER,
		FEPC_ALL
	} fepc_state_t;
endpackage

// ---- fepc_flash_controller.sv ----
`timescale 1ns/100ps
`include "fepc_regs.svh"
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// RULE1: Partial erase only on code pages.
// RULE2: Partial address write in erase mode starts chunk.
// RULE3: Chunk length in milliseconds, resets to ten.
// RULE4: Page erased when accumulated time reaches full.
// RULE5: Completed erase leaves page all ones.
// RULE6: Code fetch stalls during partial erase.
// RULE7: Incomplete accumulated erase marks page undefined.
// RULE8: Ready reads zero while busy, resets one.
// RULE9: Two-bit mode: read, write, erase.
// RULE10: Software enables write or erase only when needed.
// RULE11: Page-erase address write erases page in erase mode.
// RULE12: Software gives only code-area page addresses.
// RULE13: Two alias registers behave as page erase.
// RULE14: Full erase on one, zero does nothing.
// RULE15: User area erase on one in erase mode.
// RULE16: Software toggles erase mode around each chunk.
// RULE17: Chunk length within 1.05 of configured.
// RULE18: Write 41us, page 85ms, all 169ms busy.
// RULE19: Software writes each word at most twice.
// RULE20: Programming only clears bits, whole words.
// RULE21: Processor stalled throughout word programming.
// RULE22: Ready busy for whole chunk, then ready.
module fepc_flash_controller
	import fepc_pkg::*;
#(
	parameter int unsigned MS_CYCLES = `FEPC_MS_CYC,
	parameter int unsigned WRITE_CYCLES = `FEPC_WRITE_CYC,
	parameter int unsigned PAGE_CYCLES = `FEPC_PAGE_CYC,
	parameter int unsigned ALL_CYCLES = `FEPC_ALL_CYC
) (
	input wire logic clk,
	input wire logic nrst,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Processor word program request into flash.
	input wire logic progReq,
	input wire logic [31:0] progAddr,
	input wire logic [31:0] progData,
	input wire logic fetchActive,
	// Flash array side.
	output logic flashProgStb,
	output logic [31:0] flashProgAddr,
	output logic [31:0] flashProgData,
	output logic flashEraseStb,
	output logic [`FEPC_PAGE_BITS-1:0] flashErasePage,
	output logic flashEraseUser,
	output logic flashEraseAll,
	output logic flashPageUndefined,
	output logic cpuStall
);
	//////////////////////////////////////////////////////////////////////////
	// All state in one packed struct.
	typedef struct packed {
		// Bus side: read data and the pending write's address.
		logic [31:0] hrdata;
		logic pendWr;
		logic [11:0] pendAddr;
		// Software visible registers.
		logic [1:0] mode;
		logic [31:0] durMs;
		logic [31:0] pageAddr;
		logic [31:0] partAddr;
		logic fullTrig;
		logic userTrig;
		// Sequencer state and its cycle and millisecond counters.
		fepc_state_t state;
		logic [31:0] cnt;
		logic [31:0] msLeft;
		// Erase time gathered so far on the last partially erased page.
		logic [31:0] accum;
		logic [`FEPC_PAGE_BITS-1:0] accPage;
		logic undef;
		// Flash array side outputs.
		logic progStb;
		logic [31:0] progAddr;
		logic [31:0] progData;
		logic eraseStb;
		logic [`FEPC_PAGE_BITS-1:0] erasePage;
		logic eraseUser;
		logic full_erase_trigger;
		// Processor stall.
		logic stall;
	} fepc_regs_t;

	fepc_regs_t r; // Registered state.
	fepc_regs_t next_r; // Next state.
	logic wrDo; // Register write lands this cycle.
	logic idle; // Sequencer has no operation running.

	//////////////////////////////////////////////////////////////////////////
	// Next-state logic.
	always_comb begin
		next_r = r;
		next_r.progStb = 1'b0;
		next_r.eraseStb = 1'b0;
		idle = (r.state == FEPC_IDLE);
		wrDo = r.pendWr;
		// The slave never waits, so the address phase is taken at once.
		next_r.pendWr = hsel && hready && htrans[1] && hwrite;
		if (hsel && hready && htrans[1]) begin
			next_r.pendAddr = haddr[11:0];
			// Read data is captured for the data phase; unmapped reads give zero.
			if (haddr[11:0] == `FEPC_OFF_READY) begin
				next_r.hrdata = {31'h0, idle}; // see RULE8
			end else if (haddr[11:0] == `FEPC_OFF_CONFIG) begin
				next_r.hrdata = {30'h0, r.mode};
			end else if (haddr[11:0] == `FEPC_OFF_ERASEPG || haddr[11:0] == `FEPC_OFF_ALIASB) begin
				next_r.hrdata = r.pageAddr;
			end else if (haddr[11:0] == `FEPC_OFF_FULLERASE) begin
				next_r.hrdata = {31'h0, r.fullTrig};
			end else if (haddr[11:0] == `FEPC_OFF_USERERASE) begin
				next_r.hrdata = {31'h0, r.userTrig};
			end else if (haddr[11:0] == `FEPC_OFF_PARTADDR) begin
				next_r.hrdata = r.partAddr;
			end else if (haddr[11:0] == `FEPC_OFF_PARTDUR) begin
				next_r.hrdata = r.durMs;
			end else begin
				next_r.hrdata = 32'h0;
			end
		end
		// Register writes in the data phase; triggers start only when idle.
		if (wrDo) begin
			if (r.pendAddr == `FEPC_OFF_CONFIG) begin
				next_r.mode = hwdata[1:0]; // see RULE9
			end else if (r.pendAddr == `FEPC_OFF_ERASEPG || r.pendAddr == `FEPC_OFF_ALIASB) begin
				next_r.pageAddr = hwdata; // see RULE13
				if (idle && r.mode == `FEPC_MODE_ERASE) begin
					next_r.state = FEPC_PAGE; // see RULE11
					next_r.cnt = PAGE_CYCLES;
					next_r.erasePage = hwdata[31:`FEPC_PAGE_LSB];
					next_r.eraseStb = 1'b1;
					if (r.accPage == hwdata[31:`FEPC_PAGE_LSB]) begin
						next_r.accum = 32'h0;
						next_r.undef = 1'b0;
					end
				end
			end else if (r.pendAddr == `FEPC_OFF_FULLERASE) begin
				next_r.fullTrig = hwdata[0];
				if (hwdata[0] && idle && r.mode == `FEPC_MODE_ERASE) begin
					next_r.state = FEPC_ALL; // see RULE14
					next_r.cnt = ALL_CYCLES;
					next_r.full_erase_trigger = 1'b1;
					next_r.eraseStb = 1'b1;
					next_r.accum = 32'h0;
					next_r.undef = 1'b0;
				end
			end else if (r.pendAddr == `FEPC_OFF_USERERASE) begin
				next_r.userTrig = hwdata[0];
				if (hwdata[0] && idle && r.mode == `FEPC_MODE_ERASE) begin
					next_r.state = FEPC_USER; // see RULE15
					next_r.cnt = PAGE_CYCLES;
					next_r.eraseUser = 1'b1;
					next_r.eraseStb = 1'b1;
				end
			end else if (r.pendAddr == `FEPC_OFF_PARTADDR) begin
				next_r.partAddr = hwdata;
				// Only code pages; the user area has no partial path at all.
				if (idle && r.mode == `FEPC_MODE_ERASE && r.durMs != 32'h0) begin
					next_r.state = FEPC_PARTIAL; // see RULE2, RULE1
					next_r.cnt = MS_CYCLES;
					next_r.msLeft = r.durMs; // see RULE3
					next_r.erasePage = hwdata[31:`FEPC_PAGE_LSB];
					next_r.eraseStb = 1'b1;
					if (r.accPage != hwdata[31:`FEPC_PAGE_LSB]) begin
						next_r.accPage = hwdata[31:`FEPC_PAGE_LSB];
						next_r.accum = 32'h0;
					end
					next_r.undef = 1'b1; // see RULE7
				end
			end else if (r.pendAddr == `FEPC_OFF_PARTDUR) begin
				next_r.durMs = hwdata;
			end
		end
		// Word programming request from the processor in write mode.
		if (progReq && idle && r.mode == `FEPC_MODE_WRITE && !(wrDo && next_r.state != FEPC_IDLE)) begin
			next_r.state = FEPC_WRITE;
			next_r.cnt = WRITE_CYCLES;
			next_r.progStb = 1'b1; // see RULE20
			next_r.progAddr = {progAddr[31:2], 2'h0};
			next_r.progData = progData;
		end
		// Running operation.
		case (r.state)
			FEPC_IDLE: begin
				// Nothing runs; new requests are taken above.
			end
			// One millisecond has passed each time the tick counter runs out.
			FEPC_PARTIAL: begin
				if (r.cnt == 32'h1) begin
					next_r.cnt = MS_CYCLES;
					next_r.msLeft = r.msLeft - 32'h1;
					next_r.accum = r.accum + 32'h1;
					if (r.accum + 32'h1 >= `FEPC_PAGE_MS) begin
						next_r.accum = 32'h0; // see RULE4
						next_r.undef = 1'b0; // see RULE5
					end
					if (r.msLeft == 32'h1) begin
						next_r.state = FEPC_IDLE; // see RULE22, RULE17
					end
				end else begin
					next_r.cnt = r.cnt - 32'h1;
				end
			end
			// Write, page, user area and full erase simply count their time down.
			default: begin
				if (r.cnt == 32'h1) begin
					next_r.state = FEPC_IDLE; // see RULE18
					next_r.eraseUser = 1'b0;
					next_r.full_erase_trigger = 1'b0;
				end else begin
					next_r.cnt = r.cnt - 32'h1;
				end
			end
		endcase
		// Stall for programming, and for code fetches during any erase.
		next_r.stall = (next_r.state == FEPC_WRITE) ||
			(next_r.state != FEPC_IDLE && fetchActive); // see RULE21, RULE6
	end

	//////////////////////////////////////////////////////////////////////////
	// State register.
	// Reset leaves the mode read only and the chunk duration at ten.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			r <= '0;
			r.mode <= `FEPC_RST_MODE;
			r.durMs <= `FEPC_RST_DUR;
			r.state <= FEPC_IDLE;
		end else begin
			r <= next_r;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Outputs straight from flops, except the bus ready and response, which are tied off.
	assign hrdata = r.hrdata;
	// The slave never inserts wait states and always answers OKAY.
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign flashProgStb = r.progStb;
	assign flashProgAddr = r.progAddr;
	assign flashProgData = r.progData;
	assign flashEraseStb = r.eraseStb;
	assign flashErasePage = r.erasePage;
	assign flashEraseUser = r.eraseUser;
	assign flashEraseAll = r.full_erase_trigger;
	assign flashPageUndefined = r.undef;
	assign cpuStall = r.stall;

	//////////////////////////////////////////////////////////////////////////
	// Checks.
	sequence s_partStart;
		r.pendWr && r.pendAddr == `FEPC_OFF_PARTADDR && r.state == FEPC_IDLE &&
			r.mode == `FEPC_MODE_ERASE && r.durMs != 32'h0;
	endsequence
	// An accepted chunk request starts the partial erase at once.
	AST_PART_START: assert property (@(posedge clk) disable iff (!nrst) // see RULE2
		s_partStart |=> r.state == FEPC_PARTIAL && flashEraseStb)
		else $error("Partial erase did not start.");
	// The chunk takes its length from the duration register.
	AST_PART_LEN: assert property (@(posedge clk) disable iff (!nrst) // see RULE3
		s_partStart |=> r.msLeft == $past(r.durMs))
		else $error("Partial length not loaded.");
	// A ready read taken while busy returns zero.
	AST_READY_BUSY: assert property (@(posedge clk) disable iff (!nrst) // see RULE8
		(hsel && hready && htrans[1] && !hwrite && haddr[11:0] == `FEPC_OFF_READY &&
			r.state != FEPC_IDLE) |=> hrdata == 32'h0)
		else $error("Ready read wrong while busy.");
	// Page erase writes outside erase mode are refused.
	AST_MODE_GATE: assert property (@(posedge clk) disable iff (!nrst) // see RULE11
		(r.pendWr && r.pendAddr == `FEPC_OFF_ERASEPG && r.mode != `FEPC_MODE_ERASE &&
			r.state == FEPC_IDLE && !progReq) |=> r.state == FEPC_IDLE)
		else $error("Erase started outside erase mode.");
	// The processor waits for the whole word program.
	AST_WRITE_STALL: assert property (@(posedge clk) disable iff (!nrst) // see RULE21
		r.state == FEPC_WRITE |-> cpuStall)
		else $error("No stall while programming.");
	// A code fetch during a chunk is held off.
	AST_FETCH_STALL: assert property (@(posedge clk) disable iff (!nrst) // see RULE6
		(r.state == FEPC_PARTIAL && $past(r.state) == FEPC_PARTIAL && $past(fetchActive))
			|-> cpuStall)
		else $error("Fetch not stalled in partial erase.");
	// Writing zero to the full erase trigger does nothing.
	AST_ALL_ERASE: assert property (@(posedge clk) disable iff (!nrst) // see RULE14
		(r.pendWr && r.pendAddr == `FEPC_OFF_FULLERASE && hwdata[0] == 1'b0 &&
			r.state == FEPC_IDLE && !progReq) |=> !flashEraseStb)
		else $error("Full erase on zero.");
	// A begun chunk leaves the page undefined until fully erased.
	AST_UNDEF: assert property (@(posedge clk) disable iff (!nrst) // see RULE7
		s_partStart |=> flashPageUndefined || $past(r.accum) + 1 >= `FEPC_PAGE_MS)
		else $error("Page not marked undefined.");
	// The last tick of the last millisecond returns the sequencer to idle.
	AST_IDLE_READY: assert property (@(posedge clk) disable iff (!nrst) // see RULE22
		(r.state == FEPC_PARTIAL && r.cnt == 32'h1 && r.msLeft == 32'h1)
			|=> r.state == FEPC_IDLE)
		else $error("Partial did not end.");

	//////////////////////////////////////////////////////////////////////////
	// Further checks on the start and the course of each operation.
	// A page address write that the sequencer is free to accept.
	// Both page erase registers share this path.
	sequence s_pageStart;
		r.pendWr && (r.pendAddr == `FEPC_OFF_ERASEPG || r.pendAddr == `FEPC_OFF_ALIASB) &&
			r.state == FEPC_IDLE && r.mode == `FEPC_MODE_ERASE;
	endsequence
	// A write of one to the user area trigger while free and in erase mode.
	sequence s_userStart;
		r.pendWr && r.pendAddr == `FEPC_OFF_USERERASE && hwdata[0] &&
			r.state == FEPC_IDLE && r.mode == `FEPC_MODE_ERASE;
	endsequence
	// A write of one to the full erase trigger while free and in erase mode.
	sequence s_fullStart;
		r.pendWr && r.pendAddr == `FEPC_OFF_FULLERASE && hwdata[0] &&
			r.state == FEPC_IDLE && r.mode == `FEPC_MODE_ERASE;
	endsequence
	// A program request that the sequencer is free to accept.
	sequence s_progStart;
		progReq && r.state == FEPC_IDLE && r.mode == `FEPC_MODE_WRITE;
	endsequence
	// The page erase starts at once and strobes the addressed page.
	AST_PAGE_START: assert property (@(posedge clk) disable iff (!nrst) // see RULE11, RULE13
		s_pageStart |=> r.state == FEPC_PAGE && flashEraseStb &&
			flashErasePage == $past(hwdata[31:`FEPC_PAGE_LSB]))
		else $error("Page erase did not start.");
	// A page erase keeps running until its count is spent.
	AST_PAGE_HOLD: assert property (@(posedge clk) disable iff (!nrst) // see RULE18
		(r.state == FEPC_PAGE && r.cnt != 32'h1) |=> r.state == FEPC_PAGE)
		else $error("Page erase ended early.");
	// The user area erase starts and raises its level.
	AST_USER_START: assert property (@(posedge clk) disable iff (!nrst) // see RULE15
		s_userStart |=> r.state == FEPC_USER && flashEraseUser && flashEraseStb)
		else $error("User area erase did not start.");
	// Writing zero to the user area trigger does nothing.
	AST_USER_ZERO: assert property (@(posedge clk) disable iff (!nrst) // see RULE15
		(r.pendWr && r.pendAddr == `FEPC_OFF_USERERASE && hwdata[0] == 1'b0 &&
			r.state == FEPC_IDLE && !progReq) |=> !flashEraseStb)
		else $error("User area erase on zero.");
	// The full erase starts and raises its level.
	AST_FULL_START: assert property (@(posedge clk) disable iff (!nrst) // see RULE14
		s_fullStart |=> r.state == FEPC_ALL && flashEraseAll && flashEraseStb)
		else $error("Full erase did not start.");
	// A program request sends one aligned whole word to the array.
	AST_PROG_START: assert property (@(posedge clk) disable iff (!nrst) // see RULE20
		s_progStart |=> flashProgStb && flashProgAddr[1:0] == 2'h0 &&
			flashProgData == $past(progData))
		else $error("Word program did not start.");
	// Read only mode never programs the array.
	AST_READ_ONLY: assert property (@(posedge clk) disable iff (!nrst) // see RULE9
		(progReq && r.mode == `FEPC_MODE_READ) |=> !flashProgStb)
		else $error("Program in read only mode.");
	// Reaching the full page time clears the undefined mark.
	AST_ACCUM_DONE: assert property (@(posedge clk) disable iff (!nrst) // see RULE4
		(r.state == FEPC_PARTIAL && r.cnt == 32'h1 && r.accum + 32'h1 >= `FEPC_PAGE_MS)
			|=> !flashPageUndefined)
		else $error("Page still undefined after full time.");
	// With nothing running the processor is never held.
	AST_IDLE_NO_STALL: assert property (@(posedge clk) disable iff (!nrst) // see RULE6
		r.state == FEPC_IDLE |-> !cpuStall)
		else $error("Stall while idle.");
endmodule

// ---- fepc_flash_model.sv ----
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////////////
// Flash array model: programming can only clear bits, and erases set them to one.
module fepc_flash_model (
	input wire logic clk,
	input wire logic flashProgStb,
	input wire logic [31:0] flashProgAddr,
	input wire logic [31:0] flashProgData,
	input wire logic flashEraseStb,
	input wire logic [19:0] flashErasePage,
	input wire logic flashEraseAll
);
	// Programmed words; a word that is absent reads as erased.
	logic [31:0] mem [logic [31:0]];
	// Returns a stored word, or all ones where nothing is stored.
	function automatic logic [31:0] peek(input logic [31:0] a);
		return mem.exists(a) ? mem[a] : 32'hffffffff;
	endfunction
	// Applies the program and erase strobes at the clock edge.
	always @(posedge clk) begin : apply
		logic [31:0] kill[$];
		kill = {};
		if (flashProgStb) begin
			mem[flashProgAddr] = peek(flashProgAddr) & flashProgData;
		end
		if (flashEraseAll) begin
			mem.delete();
		end
		if (flashEraseStb) begin
			foreach (mem[k]) if (k[31:12] == flashErasePage) kill.push_back(k);
			foreach (kill[i]) mem.delete(kill[i]);
		end
	end
endmodule

// ---- flash_erase_program_controller_test.sv ----
`timescale 1ns/100ps
`include "fepc_regs.svh"
//////////////////////////////////////////////////////////////////////////////
// Self-checking bench: bus master, flash model and timing checks.
module flash_erase_program_controller_test;
	localparam int MS = 4;
	localparam int WR = 3;
	localparam int PG = 20;
	localparam int AL = 40;
	logic clk = 0;
	logic nrst = 0;
	logic hsel = 0;
	logic hwrite = 0;
	logic progReq = 0;
	logic fetchActive = 0;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 0;
	logic [31:0] haddr = 0;
	logic [31:0] hwdata = 0;
	logic [31:0] progAddr = 0;
	logic [31:0] progData = 0;
	logic [31:0] hrdata, flashProgAddr, flashProgData, rd, a, e;
	logic hready, hreadyout, hresp, flashProgStb, flashEraseStb;
	logic flashEraseUser, flashEraseAll, flashPageUndefined, cpuStall;
	logic [19:0] flashErasePage, pg;
	int err_total = 0;
	int checks = 0;
	// The clock toggles every half period of 10 ns.
	always #10 clk = ~clk;
	// The single slave drives the bus ready.
	assign hready = hreadyout;
	fepc_flash_controller #(.MS_CYCLES(MS), .WRITE_CYCLES(WR), .PAGE_CYCLES(PG),
		.ALL_CYCLES(AL)) fepc_flash_controller_inst (.clk(clk), .nrst(nrst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.progReq(progReq), .progAddr(progAddr), .progData(progData),
		.fetchActive(fetchActive), .flashProgStb(flashProgStb), .flashProgAddr(flashProgAddr),
		.flashProgData(flashProgData), .flashEraseStb(flashEraseStb),
		.flashErasePage(flashErasePage), .flashEraseUser(flashEraseUser),
		.flashEraseAll(flashEraseAll), .flashPageUndefined(flashPageUndefined),
		.cpuStall(cpuStall));
	fepc_flash_model fepc_flash_model_inst (.clk(clk), .flashProgStb(flashProgStb),
		.flashProgAddr(flashProgAddr), .flashProgData(flashProgData),
		.flashEraseStb(flashEraseStb), .flashErasePage(flashErasePage),
		.flashEraseAll(flashEraseAll));
	// Prints the counts and the verdict, then ends the run.
	task final_report;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// Compares one value and reports a mismatch at once.
	task chk(input string n, input logic [31:0] x, input logic [31:0] s);
		checks++;
		if (s !== x) begin
			$display("unexpected %s expected %h seen %h", n, x, s);
			err_total++;
		end
	endtask
	// One single word transfer: address phase, then data phase, each held until ready.
	task bus(input logic w, input logic [11:0] ad, input logic [31:0] d);
		int n;
		n = 0;
		hsel <= 1;
		htrans <= 2'h2;
		haddr <= {20'h0, ad};
		hwrite <= w;
		hsize <= 3'h2;
		do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 50);
		htrans <= 2'h0;
		hsel <= 0;
		hwdata <= d;
		do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 100);
		rd = hrdata;
		if (n >= 100) begin
			err_total++;
			final_report();
		end
	endtask
	// Reads a register and compares it.
	task rdc(input logic [11:0] ad, input logic [31:0] x, input string n);
		bus(0, ad, 32'h0);
		chk(n, x, rd);
		chk("response", 32'h0, {31'h0, hresp});
	endtask
	// Counts the cycles of one stall and checks them against a window.
	task stall(input int lo, input int hi, input string n);
		int c, t;
		c = 0;
		t = 0;
		while (t < 900 && (c == 0 || cpuStall === 1'b1)) begin
			@(posedge clk);
			t++;
			if (cpuStall === 1'b1) begin
				c++;
				progReq <= 0;
			end
		end
		checks++;
		if (t >= 900 || c < lo || c > hi) begin
			$display("unexpected %s expected %0d to %0d seen %0d", n, lo, hi, c);
			err_total++;
			if (t >= 900) final_report();
		end
	endtask
	// Main sequence of tests.
	initial begin
		void'($urandom(64));
		repeat (12) @(posedge clk);
		nrst <= 1;
		@(posedge clk);
		rdc(`FEPC_OFF_READY, `FEPC_RST_READY, "ready");
		rdc(`FEPC_OFF_CONFIG, 32'h0, "mode");
		rdc(`FEPC_OFF_PARTDUR, `FEPC_RST_DUR, "duration");
		rdc(12'h600, 32'h0, "unmapped");
		fetchActive <= 1;
		bus(1, `FEPC_OFF_ERASEPG, 32'h1000);
		repeat (3) @(posedge clk);
		chk("refused erase", 0, cpuStall);
		$display("test reset and refusal done");
		// Program a word twice, then erase its page through each register.
		for (int i = 0; i < 2; i++) begin
			pg = 20'($urandom_range(0, 47));
			a = {pg, 12'h0} + 32'($urandom_range(0, 1023) * 4);
			bus(1, `FEPC_OFF_CONFIG, {30'h0, `FEPC_MODE_WRITE});
			for (int k = 0; k < 2; k++) begin
				progData <= $urandom;
				progAddr <= a;
				progReq <= 1;
				@(posedge clk);
				e = fepc_flash_model_inst.peek(a) & progData;
				stall(WR - 1, WR + 1, "write time");
				chk("word", e, fepc_flash_model_inst.peek(a));
			end
			bus(1, `FEPC_OFF_CONFIG, {30'h0, `FEPC_MODE_ERASE});
			bus(1, i ? `FEPC_OFF_ALIASB : `FEPC_OFF_ERASEPG, {pg, 12'h0});
			stall(PG - 2, PG + 1, "page time");
			chk("page", {12'h0, pg}, {12'h0, flashErasePage});
			chk("erased", 32'hffffffff, fepc_flash_model_inst.peek(a));
			rdc(`FEPC_OFF_READY, 32'h1, "ready after");
			bus(1, `FEPC_OFF_CONFIG, {30'h0, `FEPC_MODE_READ});
		end
		$display("test program and page erase done");
		bus(1, `FEPC_OFF_CONFIG, {30'h0, `FEPC_MODE_ERASE});
		bus(1, `FEPC_OFF_FULLERASE, 32'h0);
		repeat (3) @(posedge clk);
		chk("no action", 0, cpuStall);
		bus(1, `FEPC_OFF_FULLERASE, 32'h1);
		@(posedge clk);
		chk("full", 1, flashEraseAll);
		stall(AL - 3, AL + 1, "full time");
		bus(1, `FEPC_OFF_USERERASE, 32'h1);
		@(posedge clk);
		chk("user", 1, flashEraseUser);
		stall(PG - 3, PG + 1, "user time");
		$display("test full and user erase done");
		// Two partial chunks of 43 ms make up the 85 ms page erase.
		bus(1, `FEPC_OFF_PARTDUR, 32'd43);
		for (int k = 0; k < 2; k++) begin
			bus(1, `FEPC_OFF_CONFIG, {30'h0, `FEPC_MODE_ERASE});
			bus(1, `FEPC_OFF_PARTADDR, 32'h3000);
			rdc(`FEPC_OFF_READY, 32'h0, "partial busy");
			stall(43 * MS - 4, 43 * MS * 105 / 100 + 1, "chunk");
			rdc(`FEPC_OFF_READY, 32'h1, "partial ready");
			chk("undefined", k == 0, flashPageUndefined);
			bus(1, `FEPC_OFF_CONFIG, {30'h0, `FEPC_MODE_READ});
		end
		$display("test partial erase done");
		final_report();
	end
endmodule
